/* File: hw/dpc_pkg.sv */
// Purpose: constants and types for the dual synthesiser clock control block
// Assumes: 9-bit register words on a plain strobe port
// Notes: offsets are word indices on the register port
`default_nettype none
package dpc_pkg;
	localparam logic [5:0] OFS_FIRST_FRAC_LOW = 6'h00;
	localparam logic [5:0] OFS_FIRST_FRAC_MID = 6'h01;
	localparam logic [5:0] OFS_FIRST_INT_FRAC_HIGH = 6'h02;
	localparam logic [5:0] OFS_FIRST_SCALE = 6'h03;
	localparam logic [5:0] OFS_SECOND_FRAC_LOW = 6'h04;
	localparam logic [5:0] OFS_SECOND_FRAC_MID = 6'h05;
	localparam logic [5:0] OFS_SECOND_INT_FRAC_HIGH = 6'h06;
	localparam logic [5:0] OFS_SECOND_SCALE = 6'h07;
	localparam logic [5:0] OFS_MODE_STATUS = 6'h10;
	localparam logic [5:0] OFS_POWERDOWN = 6'h33;
	localparam logic [8:0] RST_FRAC_LOW = 9'h121;
	localparam logic [8:0] RST_FRAC_MID = 9'h17e;
	localparam logic [8:0] RST_INT_FRAC_HIGH = 9'h07d;
	localparam logic [8:0] RST_SCALE = 9'h010;
	localparam logic [8:0] RST_POWERDOWN = 9'h006;
	localparam int BIT_OSC_PD = 0;
	localparam int BIT_FIRST_PD = 1;
	localparam int BIT_SECOND_PD = 2;
	localparam int BIT_IN_DIV = 0;
	localparam int BIT_OUT_HALVER = 1;
	localparam int LSB_OUT_DIVIDER = 3;
	localparam int LSB_INTEGER = 4;
	localparam logic [1:0] RX_OUT_DIVIDER = 2'h2;

	typedef struct packed {
		logic [3:0] integer_mult;
		logic [21:0] fraction;
		logic input_divider;
		logic output_halver;
		logic [1:0] output_divider;
	} dpc_synth_s;
endpackage : dpc_pkg
`default_nettype wire

/* File: hw/dpc_clock_control.sv */
// Purpose: register file and mode steering for oscillator and two clock synthesisers
// Assumes: one clock clk_sys; receiver status pins are asynchronous
`default_nettype none
module dpc_clock_control
	import dpc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [8:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [8:0] reg_rdata,
	// Receiver side, asynchronous
	input wire logic receiver_enable,
	input wire logic receiver_locked,
	input wire logic receiver_stream_present,
	input wire logic [3:0] receiver_integer,
	input wire logic [21:0] receiver_fraction,
	// Controls to the analogue synthesisers
	output logic osc_drive_powerdown,
	output logic first_synth_powerdown,
	output logic second_synth_powerdown,
	output logic first_synth_clock_enable,
	output logic second_synth_clock_enable,
	output logic receive_mode,
	output dpc_synth_s first_synth,
	output dpc_synth_s second_synth
);
	typedef enum logic [1:0] {
		DPC_USER = 2'b01,
		DPC_RECEIVE = 2'b10
	} dpc_mode_e;

	logic [8:0] regs [0:7];
	logic [8:0] next_regs [0:7];
	logic [8:0] pwr;
	logic [8:0] next_pwr;
	logic [8:0] next_reg_rdata;
	logic en_s1, en_s2, lock_s1, lock_s2, pres_s1, pres_s2;
	logic [25:0] rx_s1, rx_s2, rx_s3;
	logic [25:0] held;
	logic [25:0] next_held;
	dpc_mode_e mode;
	dpc_mode_e next_mode;
	dpc_synth_s next_first, next_second;
	logic next_first_en, next_second_en;

	// Receiver word is quasi-static; two stages keep metastability off the mux
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
			pres_s1 <= 1'b0;
			pres_s2 <= 1'b0;
			rx_s1 <= 26'h0;
			rx_s2 <= 26'h0;
			rx_s3 <= 26'h0;
		end else begin
			en_s1 <= receiver_enable;
			en_s2 <= en_s1;
			lock_s1 <= receiver_locked;
			lock_s2 <= lock_s1;
			pres_s1 <= receiver_stream_present;
			pres_s2 <= pres_s1;
			rx_s1 <= {receiver_integer, receiver_fraction};
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	// Register writes and read data
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_regs[i] = regs[i];
		end
		next_pwr = pwr;
		next_reg_rdata = 9'h000;
		if (reg_wr) begin
			if (reg_addr[5:3] == 3'h0) begin
				next_regs[reg_addr[2:0]] = reg_wdata;
			end else if (reg_addr == OFS_POWERDOWN) begin
				next_pwr = {6'h00, reg_wdata[2:0]};
			end
		end
		if (reg_rd) begin
			if (reg_addr[5:3] == 3'h0) begin
				next_reg_rdata = regs[reg_addr[2:0]];
			end else if (reg_addr == OFS_POWERDOWN) begin
				next_reg_rdata = pwr;
			end else if (reg_addr == OFS_MODE_STATUS) begin
				next_reg_rdata = {6'h00, pres_s2, lock_s2, (mode == DPC_RECEIVE)};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			regs[OFS_FIRST_FRAC_LOW[2:0]] <= RST_FRAC_LOW;
			regs[OFS_FIRST_FRAC_MID[2:0]] <= RST_FRAC_MID;
			regs[OFS_FIRST_INT_FRAC_HIGH[2:0]] <= RST_INT_FRAC_HIGH;
			regs[OFS_FIRST_SCALE[2:0]] <= RST_SCALE;
			regs[OFS_SECOND_FRAC_LOW[2:0]] <= RST_FRAC_LOW;
			regs[OFS_SECOND_FRAC_MID[2:0]] <= RST_FRAC_MID;
			regs[OFS_SECOND_INT_FRAC_HIGH[2:0]] <= RST_INT_FRAC_HIGH;
			regs[OFS_SECOND_SCALE[2:0]] <= RST_SCALE;
			pwr <= RST_POWERDOWN;
			reg_rdata <= 9'h000;
		end else begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= next_regs[i];
			end
			pwr <= next_pwr;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Mode steering and synthesiser settings
	always_comb begin
		dpc_synth_s user_a;
		dpc_synth_s user_b;
		user_a = '{integer_mult: regs[2][LSB_INTEGER +: 4],
			fraction: {regs[2][3:0], regs[1], regs[0]},
			input_divider: regs[3][BIT_IN_DIV],
			output_halver: regs[3][BIT_OUT_HALVER],
			output_divider: regs[3][LSB_OUT_DIVIDER +: 2]};
		user_b = '{integer_mult: regs[6][LSB_INTEGER +: 4],
			fraction: {regs[6][3:0], regs[5], regs[4]},
			input_divider: regs[7][BIT_IN_DIV],
			output_halver: regs[7][BIT_OUT_HALVER],
			output_divider: regs[7][LSB_OUT_DIVIDER +: 2]};
		next_mode = en_s2 ? DPC_RECEIVE : DPC_USER;
		next_held = held;
		// Two equal samples needed, so a word caught mid-change is never held
		if (en_s2 && lock_s2 && pres_s2 && (rx_s2 == rx_s3)) begin
			next_held = rx_s2;
		end
		// without a stream the last tracked multipliers stay
		next_first = user_a;
		next_second = user_b;
		next_first_en = !pwr[BIT_FIRST_PD];
		next_second_en = !pwr[BIT_SECOND_PD];
		if (en_s2) begin
			next_first.integer_mult = next_held[25:22];
			next_first.fraction = next_held[21:0];
			next_first.output_divider = RX_OUT_DIVIDER;
			next_first.output_halver = user_a.output_halver;
			next_first.input_divider = user_b.input_divider;
			next_first_en = !pwr[BIT_FIRST_PD] && (lock_s2 || !pres_s2);
			next_second_en = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode <= DPC_USER;
			held <= {RST_INT_FRAC_HIGH[7:0], RST_FRAC_MID, RST_FRAC_LOW};
			first_synth <= '0;
			second_synth <= '0;
			first_synth_clock_enable <= 1'b0;
			second_synth_clock_enable <= 1'b0;
			receive_mode <= 1'b0;
			osc_drive_powerdown <= 1'b0;
			first_synth_powerdown <= 1'b1;
			second_synth_powerdown <= 1'b1;
		end else begin
			mode <= next_mode;
			held <= next_held;
			first_synth <= next_first;
			second_synth <= next_second;
			first_synth_clock_enable <= next_first_en;
			second_synth_clock_enable <= next_second_en;
			receive_mode <= (next_mode == DPC_RECEIVE);
			osc_drive_powerdown <= pwr[BIT_OSC_PD];
			first_synth_powerdown <= pwr[BIT_FIRST_PD];
			second_synth_powerdown <= pwr[BIT_SECOND_PD];
		end
	end

	// Checks on the register and steering paths
	sequence seq_pd_write;
		reg_wr && reg_addr == OFS_POWERDOWN;
	endsequence

	sequence seq_tracking;
		en_s2 && lock_s2 && pres_s2 && (rx_s2 == rx_s3);
	endsequence

	sequence seq_unlocked;
		en_s2 && pres_s2 && !lock_s2;
	endsequence

	sequence seq_status_read;
		reg_rd && reg_addr == OFS_MODE_STATUS;
	endsequence

	AST_PD_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == OFS_POWERDOWN |=> ##1 first_synth_powerdown == $past(reg_wdata[1], 2))
		else $error("first powerdown did not follow write");

	AST_SECOND_PD_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!resetn)
		seq_pd_write |=> ##1 second_synth_powerdown == $past(reg_wdata[2], 2))
		else $error("second powerdown did not follow write");

	AST_OSC_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == OFS_POWERDOWN |=> ##1 osc_drive_powerdown == $past(reg_wdata[0], 2))
		else $error("oscillator powerdown did not follow write");

	AST_MODE: assert property (@(posedge clk_sys) disable iff (!resetn)
		receive_mode |-> first_synth.output_divider == RX_OUT_DIVIDER && !second_synth_clock_enable)
		else $error("mode output disagrees with steering");

	AST_UNLOCK_STOP: assert property (@(posedge clk_sys) disable iff (!resetn)
		seq_unlocked |=> !first_synth_clock_enable)
		else $error("first clock runs while unlocked");

	AST_RUN_NO_STREAM: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 && !pres_s2 && !pwr[BIT_FIRST_PD] |=> first_synth_clock_enable)
		else $error("first clock stopped without stream");

	AST_SECOND_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 |=> !second_synth_clock_enable)
		else $error("second clock enabled in receive mode");

	AST_SECOND_USER_EN: assert property (@(posedge clk_sys) disable iff (!resetn)
		!en_s2 |=> second_synth_clock_enable == !$past(pwr[BIT_SECOND_PD]))
		else $error("second clock enable ignores powerdown");

	AST_FIRST_PD_STOP: assert property (@(posedge clk_sys) disable iff (!resetn)
		pwr[BIT_FIRST_PD] |=> !first_synth_clock_enable)
		else $error("first clock runs while powered down");

	AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 && $past(en_s2) && !pres_s2 |=> $stable(first_synth.fraction))
		else $error("fraction moved without stream");

	AST_TRACK: assert property (@(posedge clk_sys) disable iff (!resetn)
		seq_tracking |=> first_synth.fraction == $past(rx_s2[21:0]))
		else $error("tracked fraction not applied");

	AST_RX_DIVIDER: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 |=> first_synth.output_divider == RX_OUT_DIVIDER)
		else $error("receive output divider not forced");

	AST_RX_PRESCALE: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 |=> first_synth.input_divider == $past(regs[7][BIT_IN_DIV]))
		else $error("first input divider not taken from second");

	AST_USER_FRAC: assert property (@(posedge clk_sys) disable iff (!resetn)
		!en_s2 |=> second_synth.fraction == $past({regs[6][3:0], regs[5], regs[4]}))
		else $error("user fraction not applied");

	AST_USER_FIRST_FRAC: assert property (@(posedge clk_sys) disable iff (!resetn)
		!en_s2 |=> first_synth.fraction == $past({regs[2][3:0], regs[1], regs[0]}))
		else $error("first user fraction not applied");

	AST_USER_FIRST_INT: assert property (@(posedge clk_sys) disable iff (!resetn)
		!en_s2 |=> first_synth.integer_mult == $past(regs[2][LSB_INTEGER +: 4]))
		else $error("first user integer not applied");

	AST_SECOND_INT: assert property (@(posedge clk_sys) disable iff (!resetn)
		!en_s2 |=> second_synth.integer_mult == $past(regs[6][LSB_INTEGER +: 4]))
		else $error("second integer not applied");

	AST_READBACK: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_rd && !reg_wr && reg_addr == OFS_FIRST_FRAC_LOW |=> reg_rdata == $past(regs[0]))
		else $error("readback mismatch");

	AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
		seq_status_read |=> reg_rdata[2:0] == $past({pres_s2, lock_s2, mode == DPC_RECEIVE}))
		else $error("status readback mismatch");

	AST_HALVER: assert property (@(posedge clk_sys) disable iff (!resetn)
		en_s2 |=> first_synth.output_halver == $past(regs[3][BIT_OUT_HALVER]))
		else $error("halver select lost");
endmodule // dpc_clock_control
`default_nettype wire

/* File: tb/dpc_rx_model.sv */
// Purpose: stand-in for the receiver that steers the first synthesiser
// Assumes: bench commands change just after a rising clock edge
// Notes: tracking value is junk while no stream is present
`default_nettype none
module dpc_rx_model (
	// Clock
	input wire logic clk_sys,
	// Bench commands
	input wire logic en_cmd,
	input wire logic lock_cmd,
	input wire logic present_cmd,
	input wire logic [25:0] mult_cmd,
	// Towards the design
	output logic receiver_enable,
	output logic receiver_locked,
	output logic receiver_stream_present,
	output logic [3:0] receiver_integer,
	output logic [21:0] receiver_fraction
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_sys) begin
		receiver_enable <= en_cmd;
		receiver_locked <= lock_cmd & present_cmd & en_cmd;
		receiver_stream_present <= present_cmd & en_cmd;
		// No stream: toggle so a design that fails to freeze shows it
		{receiver_integer, receiver_fraction} <= present_cmd ? mult_cmd
			: ~{receiver_integer, receiver_fraction};
	end
endmodule // dpc_rx_model
`default_nettype wire

/* File: tb/tb_dpc_clock_control.sv */
// Purpose: self-checking bench for the synthesiser clock control block
// Assumes: receiver stand-in adds one cycle before the design's sync
// Notes: levels are sampled five cycles after each cause
`default_nettype none
module tb_dpc_clock_control;
	import dpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic [5:0] reg_addr = 0;
	logic [8:0] reg_wdata = 0, reg_rdata;
	logic en_cmd = 0, lock_cmd = 0, present_cmd = 0;
	logic [25:0] mult_cmd = 0;
	logic rx_en, rx_lock, rx_pres, osc_pd, first_pd, second_pd, first_ce, second_ce, rx_mode;
	logic [3:0] rx_int;
	logic [21:0] rx_frac;
	dpc_synth_s first_synth, second_synth;
	int n_fail = 0, check_count = 0;
	logic [5:0] ofs [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h33};
	logic [8:0] rst [7] = '{9'h121, 9'h17e, 9'h07d, 9'h121, 9'h17e, 9'h07d, 9'h006};
	always #5 clk_sys = ~clk_sys;
	dpc_rx_model i_rx (.clk_sys(clk_sys), .en_cmd(en_cmd), .lock_cmd(lock_cmd),
		.present_cmd(present_cmd), .mult_cmd(mult_cmd), .receiver_enable(rx_en),
		.receiver_locked(rx_lock), .receiver_stream_present(rx_pres),
		.receiver_integer(rx_int), .receiver_fraction(rx_frac));
	dpc_clock_control i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.receiver_enable(rx_en), .receiver_locked(rx_lock), .receiver_stream_present(rx_pres),
		.receiver_integer(rx_int), .receiver_fraction(rx_frac), .osc_drive_powerdown(osc_pd),
		.first_synth_powerdown(first_pd), .second_synth_powerdown(second_pd),
		.first_synth_clock_enable(first_ce), .second_synth_clock_enable(second_ce),
		.receive_mode(rx_mode), .first_synth(first_synth), .second_synth(second_synth));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [8:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_check(input string name, input logic [5:0] a, input logic [8:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(name, reg_rdata, exp);
	endtask
	task automatic settle;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd_check("reset value", ofs[i], rst[i]);
		check("pd levels", {osc_pd, first_pd, second_pd}, 3'b011);
		wr(OFS_POWERDOWN, 9'h1f9);
		settle();
		rd_check("pd readback", OFS_POWERDOWN, 9'h001);
		check("pd levels", {osc_pd, first_pd, second_pd}, 3'b100);
		wr(6'h00, 9'h0aa);
		wr(6'h01, 9'h155);
		wr(6'h02, 9'h083);
		wr(6'h04, 9'h1c3);
		wr(6'h05, 9'h03c);
		wr(6'h06, 9'h0ba);
		wr(6'h3f, 9'h1ff);
		settle();
		check("first mult", first_synth[29:4], {4'h8, 4'h3, 9'h155, 9'h0aa});
		check("second mult", second_synth[29:4], {4'hb, 4'ha, 9'h03c, 9'h1c3});
		check("second scale", second_synth[3:0], 4'b0010);
		rd_check("unmapped", 6'h3f, 9'h000);
		check("clock en", {first_ce, second_ce}, 2'b11);
		wr(OFS_FIRST_SCALE, 9'h003);
		wr(OFS_SECOND_SCALE, 9'h001);
		mult_cmd <= {4'h9, 22'h12345};
		en_cmd <= 1'b1;
		lock_cmd <= 1'b1;
		present_cmd <= 1'b1;
		settle();
		check("rx mode", rx_mode, 1'b1);
		check("rx mult", first_synth[29:4], {4'h9, 22'h12345});
		check("rx div", first_synth.output_divider, RX_OUT_DIVIDER);
		check("rx halver", first_synth.output_halver, 1'b1);
		check("rx prescale", first_synth.input_divider, 1'b1);
		check("rx clocks", {first_ce, second_ce}, 2'b10);
		rd_check("rx status", OFS_MODE_STATUS, 9'h007);
		@(posedge clk_sys);
		present_cmd <= 1'b0;
		mult_cmd <= {4'h6, 22'h3abcd};
		settle();
		check("frozen", {first_synth[29:4], first_ce}, {4'h9, 22'h12345, 1'b1});
		@(posedge clk_sys);
		present_cmd <= 1'b1;
		lock_cmd <= 1'b0;
		settle();
		check("unlocked clock", first_ce, 1'b0);
		@(posedge clk_sys);
		lock_cmd <= 1'b1;
		settle();
		check("relocked", {first_synth[29:4], first_ce}, {4'h6, 22'h3abcd, 1'b1});
		@(posedge clk_sys);
		en_cmd <= 1'b0;
		settle();
		check("user mode", rx_mode, 1'b0);
		check("user again", first_synth, {4'h8, 4'h3, 9'h155, 9'h0aa, 4'b1100});
		report_and_stop();
	end
endmodule // tb_dpc_clock_control
`default_nettype wire
